// ---- spdwp_ctrl.sv ----
// two-wire slave front end with write-protection of the lower memory area
// assumes an array that takes byte strobes and reports its write cycle as busy
// Summary of operation
// - permanent protection: write-direction protection commands get no acknowledge at all
// - protected lower area: acknowledge selector and address, refuse data, no cycle
// - control pin low: set refused when protected, protection commands refused after permanent lock, lower-area data refused when protected, rest acknowledged
// - permanent protection: read-direction protection selectors get no acknowledge
// - read direction: selector acknowledged when allowed, address and data never
// - set makes lower area read-only; clear makes it writable again
// - permanent command accepted without high voltage on address pin zero
// - after permanent protection, no protection selector is ever acknowledged again
// - a refused data byte leaves the addressed location untouched
// - write cycle starts only on stop in the slot right after an acknowledge
`include "spdwp_params.svh"

module spdwp_ctrl (
  input wire logic clk, // system clock, 10 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value
  output logic sda_oe, // serial data drive enable
  input wire logic write_control_pin, // high blocks writes
  input wire logic high_voltage_level, // high voltage seen on address pin zero
  input wire logic [2:0] chip_addr_pins, // chip address pins a2..a0
  input wire logic wr_busy, // internal write cycle in progress
  input wire logic nv_rev_prot, // stored reversible protection
  input wire logic nv_perm_prot, // stored permanent protection
  output logic nv_write, // pulse: program protection cells
  output logic nv_rev_out, // reversible value to program
  output logic nv_perm_out, // permanent value to program
  output logic mem_byte_valid, // pulse: accepted data byte
  output logic [7:0] mem_byte_addr, // address of accepted byte
  output logic [7:0] mem_byte_data, // accepted byte
  output logic mem_cycle_start, // pulse: start array write cycle
  output logic [7:0] mem_rd_addr, // current read address
  input wire logic [7:0] mem_rd_data // array byte at mem_rd_addr
);
  import spdwp_pkg::*;

  logic [`SPDWP_SYNC_W-1:0] lvl;
  logic scl_f, sda_f, wc_f, hv_f;
  logic [2:0] pins_f;
  logic scl_prev_q, sda_prev_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  spdwp_pin_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pins({chip_addr_pins, high_voltage_level, write_control_pin, sda_in, scl_in}),
    .level(lvl)
  );

  // filtered pin levels and bus events
  assign scl_f = lvl[`SPDWP_PIN_SCL];
  assign sda_f = lvl[`SPDWP_PIN_SDA];
  assign wc_f = lvl[`SPDWP_PIN_WC];
  assign hv_f = lvl[`SPDWP_PIN_HV];
  assign pins_f = lvl[`SPDWP_PIN_A2:`SPDWP_PIN_A0];
  assign scl_rise = scl_f & ~scl_prev_q;
  assign scl_fall = ~scl_f & scl_prev_q;
  assign bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign bus_stop = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  // acknowledge of the selector byte
  function automatic logic sel_ack(spdwp_kind_type k, logic rd, logic rev, logic perm);
    if (k == K_MEM) begin
      sel_ack = 1'b1;
    end else if (perm) begin
      sel_ack = 1'b0;
    end else if (k == K_SET && rev) begin
      sel_ack = 1'b0;
    end else begin
      sel_ack = 1'b1;
    end
  endfunction

  // acknowledge of a data byte in the write direction
  function automatic logic data_ack(spdwp_kind_type k, logic [7:0] a, logic wc,
                                    logic rev, logic perm);
    if (wc) begin
      data_ack = 1'b0;
    end else if (k == K_MEM) begin
      data_ack = !((a < `SPDWP_LOWER_LIMIT) && (rev || perm));
    end else begin
      data_ack = 1'b1;
    end
  endfunction

  spdwp_state_type state_q, state_d;
  spdwp_phase_type phase_q, phase_d;
  spdwp_kind_type kind_q, kind_d;
  logic [7:0] shift_q, shift_d, addr_q, addr_d;
  logic [3:0] cnt_q, cnt_d;
  logic rd_q, rd_d, ack_q, ack_d, pend_q, pend_d, slot10_q, slot10_d;
  logic rev_q, rev_d, perm_q, perm_d, oe_q, oe_d;
  logic nvw_q, nvw_d, byte_v_q, byte_v_d, cyc_q, cyc_d;
  logic [7:0] byte_a_q, byte_a_d, byte_q, byte_d;
  spdwp_kind_type k_new;

  // protocol engine next state
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    kind_d = kind_q;
    shift_d = shift_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    ack_d = ack_q;
    pend_d = pend_q;
    slot10_d = slot10_q;
    rev_d = rev_q;
    perm_d = perm_q;
    oe_d = oe_q;
    nvw_d = 1'b0;
    byte_v_d = 1'b0;
    cyc_d = 1'b0;
    byte_a_d = byte_a_q;
    byte_d = byte_q;
    k_new = K_MEM;
    if (scl_fall) begin
      slot10_d = 1'b0; // next clock fall after the ack slot closes the tenth slot
    end
    if (state_q == ST_LOAD) begin
      rev_d = nv_rev_prot;
      perm_d = nv_perm_prot;
      state_d = ST_IDLE;
    end else if (wr_busy) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
      pend_d = 1'b0;
    end else if (bus_stop) begin
      if (slot10_q && pend_q) begin
        // commit only on stop in the tenth slot
        if (kind_q == K_MEM) begin
          cyc_d = 1'b1;
        end else begin
          nvw_d = 1'b1;
          if (kind_q == K_SET) begin
            rev_d = 1'b1;
          end else if (kind_q == K_CLR) begin
            rev_d = 1'b0;
          end else begin
            perm_d = 1'b1;
          end
        end
      end
      state_d = ST_IDLE;
      oe_d = 1'b0;
      pend_d = 1'b0;
    end else if (bus_start) begin
      state_d = ST_RECV;
      phase_d = PH_SEL;
      cnt_d = `SPDWP_RST_CNT;
      oe_d = 1'b0;
      pend_d = 1'b0;
    end else begin
      case (state_q)
        ST_RECV: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_f};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `SPDWP_BITS_PER_BYTE) begin
            state_d = ST_ACK;
            if (phase_q == PH_SEL) begin
              rd_d = shift_q[0];
              if (shift_q[7:4] == `SPDWP_TYPE_MEM && shift_q[3:1] == pins_f) begin
                k_new = K_MEM;
              end else if (shift_q[7:4] != `SPDWP_TYPE_PROT) begin
                state_d = ST_IGNORE;
              end else if (shift_q[3:1] == `SPDWP_SET_CODE && hv_f) begin
                k_new = K_SET;
              end else if (shift_q[3:1] == `SPDWP_CLR_CODE && hv_f) begin
                k_new = K_CLR;
              end else if (shift_q[3:1] == pins_f) begin
                k_new = K_PERM; // no high voltage needed
              end else begin
                state_d = ST_IGNORE;
              end
              kind_d = k_new;
              ack_d = sel_ack(k_new, shift_q[0], rev_q, perm_q);
            end else if (phase_q == PH_ADDR) begin
              ack_d = 1'b1;
              addr_d = shift_q;
            end else begin
              ack_d = data_ack(kind_q, addr_q, wc_f, rev_q, perm_q);
              if (ack_d) begin
                pend_d = 1'b1;
                if (kind_q == K_MEM) begin
                  byte_v_d = 1'b1;
                  byte_a_d = addr_q;
                  byte_d = shift_q;
                  addr_d = {addr_q[7:4], addr_q[3:0] + 4'h1};
                end
              end else begin
                pend_d = 1'b0; // refused byte, no cycle
              end
            end
            if (state_d == ST_ACK) begin
              oe_d = ack_d;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            cnt_d = `SPDWP_RST_CNT;
            slot10_d = ack_q;
            if (!ack_q) begin
              state_d = ST_IGNORE;
            end else if (phase_q == PH_SEL && rd_q) begin
              if (kind_q == K_MEM) begin
                state_d = ST_SEND;
                shift_d = mem_rd_data;
                oe_d = ~mem_rd_data[7];
              end else begin
                state_d = ST_IGNORE; // address and data slots unanswered
              end
            end else begin
              state_d = ST_RECV;
              phase_d = (phase_q == PH_SEL) ? PH_ADDR : PH_DATA;
            end
          end
        end
        ST_SEND: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == `SPDWP_BITS_PER_BYTE) begin
              oe_d = 1'b0;
              state_d = ST_MACK;
              addr_d = addr_q + 8'h01;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_d = ~shift_q[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            ack_d = ~sda_f;
          end else if (scl_fall) begin
            cnt_d = `SPDWP_RST_CNT;
            if (ack_q) begin
              state_d = ST_SEND;
              shift_d = mem_rd_data;
              oe_d = ~mem_rd_data[7];
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        default: begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // protocol engine registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_LOAD;
      phase_q <= PH_SEL;
      kind_q <= K_MEM;
      shift_q <= `SPDWP_RST_BYTE;
      addr_q <= `SPDWP_RST_ADDR;
      cnt_q <= `SPDWP_RST_CNT;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      pend_q <= 1'b0;
      slot10_q <= 1'b0;
      rev_q <= 1'b0;
      perm_q <= 1'b0;
      oe_q <= 1'b0;
      nvw_q <= 1'b0;
      byte_v_q <= 1'b0;
      cyc_q <= 1'b0;
      byte_a_q <= `SPDWP_RST_ADDR;
      byte_q <= `SPDWP_RST_BYTE;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      kind_q <= kind_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      ack_q <= ack_d;
      pend_q <= pend_d;
      slot10_q <= slot10_d;
      rev_q <= rev_d;
      perm_q <= perm_d;
      oe_q <= oe_d;
      nvw_q <= nvw_d;
      byte_v_q <= byte_v_d;
      cyc_q <= cyc_d;
      byte_a_q <= byte_a_d;
      byte_q <= byte_d;
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  // outputs straight from registers, data drive value tied low
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign nv_write = nvw_q;
  assign nv_rev_out = rev_q;
  assign nv_perm_out = perm_q;
  assign mem_byte_valid = byte_v_q;
  assign mem_byte_addr = byte_a_q;
  assign mem_byte_data = byte_q;
  assign mem_cycle_start = cyc_q;
  assign mem_rd_addr = addr_q;
endmodule

// ---- spdwp_params.svh ----
// constants for the presence-detect write-protect controller
// assumes inclusion by the controller, synchroniser, checker and bench files
`ifndef SPDWP_PARAMS_SVH
`define SPDWP_PARAMS_SVH

// selector type codes, upper four bits of the selector byte
`define SPDWP_TYPE_MEM 4'ha
`define SPDWP_TYPE_PROT 4'h6
// chip-address field of set and clear protection commands
`define SPDWP_SET_CODE 3'h1
`define SPDWP_CLR_CODE 3'h3
// first address above the protectable lower area
`define SPDWP_LOWER_LIMIT 8'h80
// reset values and bits per byte
`define SPDWP_RST_ADDR 8'h00
`define SPDWP_RST_BYTE 8'h00
`define SPDWP_RST_CNT 4'h0
`define SPDWP_BITS_PER_BYTE 4'h8
// pin synchroniser width and bit positions
`define SPDWP_SYNC_W 7
`define SPDWP_SYNC_RST 7'h03 // clock and data wires idle high, no false edge after reset
`define SPDWP_PIN_SCL 0
`define SPDWP_PIN_SDA 1
`define SPDWP_PIN_WC 2
`define SPDWP_PIN_HV 3
`define SPDWP_PIN_A0 4
`define SPDWP_PIN_A2 6

`endif

// ---- spdwp_pkg.sv ----
// types shared by the write-protect controller
// assumes the params header sits in the same folder
package spdwp_pkg;
  typedef enum logic [2:0] {
    ST_LOAD, ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK, ST_IGNORE
  } spdwp_state_type;

  typedef enum logic [1:0] {PH_SEL, PH_ADDR, PH_DATA} spdwp_phase_type;

  typedef enum logic [1:0] {K_MEM, K_SET, K_CLR, K_PERM} spdwp_kind_type;
endpackage

// ---- spdwp_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to clk
`include "spdwp_params.svh"

module spdwp_pin_sync (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [`SPDWP_SYNC_W-1:0] pins, // raw pin levels
  output logic [`SPDWP_SYNC_W-1:0] level // filtered levels
);
  logic [`SPDWP_SYNC_W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // accept a change only once stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < `SPDWP_SYNC_W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  // synchroniser chain and filtered value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= `SPDWP_SYNC_RST;
      s2_q <= `SPDWP_SYNC_RST;
      s3_q <= `SPDWP_SYNC_RST;
      lvl_q <= `SPDWP_SYNC_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule

// ---- spdwp_ctrl_props.sv ----
// port-level checker for the write-protect controller
// assumes the bind below attaches it to every controller instance
`include "spdwp_params.svh"

module spdwp_ctrl_props (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data wire
  input wire logic sda_out, // data drive value
  input wire logic sda_oe, // data drive enable
  input wire logic write_control_pin, // write block pin
  input wire logic high_voltage_level, // high voltage on pin zero
  input wire logic wr_busy, // write cycle running
  input wire logic nv_rev_prot, // stored reversible state
  input wire logic nv_perm_prot, // stored permanent state
  input wire logic nv_write, // cell program pulse
  input wire logic nv_rev_out, // reversible state
  input wire logic nv_perm_out, // permanent state
  input wire logic mem_byte_valid, // accepted byte pulse
  input wire logic [7:0] mem_byte_addr, // accepted byte address
  input wire logic mem_cycle_start // array cycle pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // open-drain data line, only pulls low
  a_sda_low_only: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  // ack drive moves only while the clock is low, so the host reads a steady bit
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  a_perm_no_write: assert property ($past(nv_perm_out) && nv_perm_out |-> !nv_write)
    else $error("protection cells written after permanent lock");
  a_perm_sticky: assert property (nv_perm_out |=> nv_perm_out)
    else $error("permanent protection dropped");
  a_lower_guard: assert property (mem_byte_valid && (nv_rev_out || nv_perm_out)
      |-> mem_byte_addr >= `SPDWP_LOWER_LIMIT)
    else $error("byte accepted in protected lower area");
  a_wc_blocks: assert property (write_control_pin [*8] |-> !mem_byte_valid && !nv_write)
    else $error("write accepted with control pin high");
  a_rev_needs_hv: assert property (nv_write && !nv_perm_out |-> high_voltage_level)
    else $error("set or clear taken without high voltage");
  a_cycle_on_stop: assert property (mem_cycle_start || nv_write |-> scl_in && sda_in)
    else $error("write cycle started outside stop");
  a_busy_quiet: assert property (wr_busy [*2] |-> !sda_oe)
    else $error("bus answered during write cycle");
  a_nv_reload: assert property ($fell(sys_rst) |-> ##[1:2]
      (nv_perm_out == nv_perm_prot && nv_rev_out == nv_rev_prot))
    else $error("protection state not reloaded");
endmodule

bind spdwp_ctrl spdwp_ctrl_props spdwp_ctrl_props_inst (.clk, .sys_rst, .scl_in, .sda_in,
  .sda_out, .sda_oe, .write_control_pin, .high_voltage_level, .wr_busy, .nv_rev_prot,
  .nv_perm_prot, .nv_write, .nv_rev_out, .nv_perm_out, .mem_byte_valid, .mem_byte_addr,
  .mem_cycle_start);

// ---- spdwp_host_model.sv ----
// two-wire bus master model issuing three-byte commands
// assumes sda is the resolved wire with pull-up; idle clock stays high
module spdwp_host_model (
  input wire logic clk, // system clock
  input wire logic sda, // resolved data wire
  output logic scl, // serial clock
  output logic sda_m, // data drive, 1 releases
  output logic hv // high voltage on address pin zero
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    hv = 1'b0;
  end
  // wait falling edges
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one bit slot, wire sampled mid-high
  task automatic bit_slot(input logic b, output logic s);
    scl = 1'b0;
    tk(3);
    sda_m = b;
    tk(8);
    scl = 1'b1;
    tk(5);
    s = sda;
    tk(5);
  endtask
  // eight bits msb first, then released ack slot
  task automatic send_byte(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, s);
    a = ~s;
  endtask
  // start, selector, two bytes, stop; high voltage held throughout
  task automatic xfer(input logic [7:0] sel, input logic [7:0] adr, input logic h,
      output logic [2:0] acks);
    hv = h;
    tk(4);
    sda_m = 1'b0;
    tk(6);
    send_byte(sel, acks[2]);
    send_byte(adr, acks[1]);
    send_byte(adr, acks[0]);
    scl = 1'b0;
    sda_m = 1'b0;
    tk(6);
    scl = 1'b1;
    tk(6);
    sda_m = 1'b1;
    tk(12);
    hv = 1'b0;
  endtask
  // start, read selector, one byte read back without master ack, stop
  task automatic rd(input logic [7:0] sel, output logic a, output logic [7:0] d);
    logic s;
    tk(4);
    sda_m = 1'b0;
    tk(6);
    send_byte(sel, a);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      d[i] = s;
    end
    bit_slot(1'b1, s);
    scl = 1'b0;
    sda_m = 1'b0;
    tk(6);
    scl = 1'b1;
    tk(6);
    sda_m = 1'b1;
    tk(12);
  endtask
endmodule

// ---- spdwp_ctrl_tb.sv ----
// self-checking bench for the write-protect controller
// assumes the host model and the checker are compiled alongside
`include "spdwp_params.svh"

module spdwp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] sel_mem = {`SPDWP_TYPE_MEM, 4'h0};
  localparam logic [7:0] sel_set = {`SPDWP_TYPE_PROT, `SPDWP_SET_CODE, 1'b0};
  localparam logic [7:0] sel_clr = {`SPDWP_TYPE_PROT, `SPDWP_CLR_CODE, 1'b0};
  localparam logic [7:0] sel_perm = {`SPDWP_TYPE_PROT, 4'h0};
  localparam logic [7:0] sels [3] = '{sel_set, sel_clr, sel_perm};
  logic clk, sys_rst, scl, sda_m, hv, sda_oe, sda_out, sda_w, wc, wr_busy;
  logic nv_rev_q, nv_perm_q, nv_write, nv_rev_out, nv_perm_out, mem_byte_valid;
  logic mem_cycle_start;
  logic [7:0] mem_byte_addr, mem_byte_data, mem_rd_addr;
  logic [2:0] acks;
  logic [7:0] rd_data;
  int num_errors, compares, ev_cnt, busy_cnt;
  assign sda_w = sda_oe ? sda_out : sda_m;
  assign wr_busy = busy_cnt != 0;
  spdwp_ctrl spdwp_ctrl_inst (.clk, .sys_rst, .scl_in(scl), .sda_in(sda_w), .sda_out,
    .sda_oe, .write_control_pin(wc), .high_voltage_level(hv), .chip_addr_pins(3'h0),
    .wr_busy, .nv_rev_prot(nv_rev_q), .nv_perm_prot(nv_perm_q), .nv_write, .nv_rev_out,
    .nv_perm_out, .mem_byte_valid, .mem_byte_addr, .mem_byte_data, .mem_cycle_start,
    .mem_rd_addr, .mem_rd_data(~mem_rd_addr));
  spdwp_host_model spdwp_host_model_inst (.clk, .sda(sda_w), .scl, .sda_m, .hv);
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // protection cells and write-cycle busy model
  always @(negedge clk) begin
    if (nv_write === 1'b1) begin
      nv_rev_q <= nv_rev_out;
      nv_perm_q <= nv_perm_out;
    end
    if (nv_write === 1'b1 || mem_cycle_start === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
      busy_cnt <= 20;
    end else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one command, wait out its write cycle, judge acks and cycle count
  task automatic cmd(input string what, input logic [7:0] sel, input logic [7:0] adr,
      input logic h, input logic [2:0] ea, input int ee);
    int e0;
    e0 = ev_cnt;
    spdwp_host_model_inst.xfer(sel, adr, h, acks);
    for (int n = 0; wr_busy !== 1'b0; n++) begin
      if (n > 100) begin
        num_errors++;
        end_of_test();
      end
      @(negedge clk);
    end
    check({what, " acks"}, {5'h00, acks}, {5'h00, ea});
    check({what, " cycles"}, 8'(ev_cnt - e0), 8'(ee));
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  task automatic t_unprot();
    for (int i = 0; i < 3; i++) cmd("rd open", sels[i] | 8'h01, 8'hff, i != 2, 3'h4, 0);
    wc = 1'b1;
    cmd("wc high", sel_mem, 8'h90, 1'b0, 3'h6, 0);
    wc = 1'b0;
    cmd("open wr", sel_mem, 8'h10, 1'b0, 3'h7, 1);
    check("byte addr", mem_byte_addr, 8'h10);
    check("byte data", mem_byte_data, 8'h10);
    cmd("set", sel_set, 8'h00, 1'b1, 3'h7, 1);
    check("rev on", {7'h00, nv_rev_out}, 8'h01);
  endtask
  task automatic t_rev();
    cmd("rd set rev", sel_set | 8'h01, 8'hff, 1'b1, 3'h0, 0);
    cmd("rd clr rev", sel_clr | 8'h01, 8'hff, 1'b1, 3'h4, 0);
    cmd("rd perm rev", sel_perm | 8'h01, 8'hff, 1'b0, 3'h4, 0);
    cmd("set rev", sel_set, 8'h00, 1'b1, 3'h0, 0);
    cmd("low wr", sel_mem, 8'h10, 1'b0, 3'h6, 0);
    cmd("edge wr", sel_mem, 8'h7f, 1'b0, 3'h6, 0);
    cmd("high wr", sel_mem, 8'h80, 1'b0, 3'h7, 1);
    cmd("clr no hv", sel_clr, 8'h00, 1'b0, 3'h0, 0);
    cmd("clr", sel_clr, 8'h00, 1'b1, 3'h7, 1);
    check("rev off", {7'h00, nv_rev_out}, 8'h00);
    cmd("low wr open", sel_mem, 8'h20, 1'b0, 3'h7, 1);
  endtask
  task automatic t_perm();
    cmd("set again", sel_set, 8'h00, 1'b1, 3'h7, 1);
    cmd("perm", sel_perm, 8'h00, 1'b0, 3'h7, 1);
    check("perm on", {7'h00, nv_perm_out}, 8'h01);
    for (int i = 0; i < 3; i++) cmd("wr locked", sels[i], 8'h00, i != 2, 3'h0, 0);
    for (int i = 0; i < 3; i++) cmd("rd locked", sels[i] | 8'h01, 8'hff, i != 2, 3'h0, 0);
    cmd("low wr lock", sel_mem, 8'h10, 1'b0, 3'h6, 0);
    // memory reads stay open; array model returns inverted address, counter at 10h
    spdwp_host_model_inst.rd(sel_mem | 8'h01, acks[2], rd_data);
    check("rd mem ack", {7'h00, acks[2]}, 8'h01);
    check("rd mem data", rd_data, 8'hef);
  endtask
  task automatic t_reload();
    wc = 1'b1;
    do_reset();
    check("perm kept", {7'h00, nv_perm_out}, 8'h01);
    cmd("perm after rst", sel_perm, 8'h00, 1'b0, 3'h0, 0);
    wc = 1'b0;
    cmd("clr after rst", sel_clr, 8'h00, 1'b1, 3'h0, 0);
    cmd("high after rst", sel_mem, 8'h90, 1'b0, 3'h7, 1);
  endtask
  // main sequence
  initial begin
    sys_rst = 1'b1;
    wc = 1'b0;
    nv_rev_q = 1'b0;
    nv_perm_q = 1'b0;
    ev_cnt = 0;
    busy_cnt = 0;
    do_reset();
    t_unprot();
    t_rev();
    t_perm();
    t_reload();
    end_of_test();
  end
endmodule
